// *** inc/counter_mode_defs.svh ***
// Register offsets, field positions and reset values of the counter mode/control bank
`ifndef COUNTER_MODE_DEFS_SVH
`define COUNTER_MODE_DEFS_SVH

// Register indices; the byte address is four times the index
`define IDX_MODE0_STD 4'h5
`define IDX_MODE1_STD 4'hD
`define IDX_CTRL0_STD 4'h6
`define IDX_MODE0_CMP 4'hA
`define IDX_MODE1_CMP 4'hB
`define IDX_CTRL0_CMP 4'hC
`define IDX_IRQ_STATUS 4'h0
`define IDX_IRQ_CLEAR 4'h1

`define MODE_FUNC_BIT 7
`define MODE_GATE_BIT 6
`define MODE_HYST_BIT 5
`define MODE_ZERO_BIT 4
`define MODE_EDGE_MSB 3
`define MODE_EDGE_X4 4'h0
`define MODE_EDGE_X2 4'h1
`define MODE_EDGE_X1 4'h5
`define CTRL_ZM0_EN_BIT 7
`define CTRL_ZM1_EN_BIT 6
`define CTRL_SPEC_EN_BIT 5
`define CTRL_COMPAT_BIT 4
`define CLR_ZM0_BIT 0
`define CLR_SPEC_BIT 1
`define CLR_ZM1_BIT 8
`define REG_RESET 8'h00
`define MODE_RD_MASK 8'hEF

`endif

// *** inc/counter_mode_pkg.sv ***
// Types shared by the counter mode/control bank
package counter_mode_pkg;
    typedef enum logic [1:0] {
        bus_idle,
        bus_write,
        bus_read
    } bus_phase_t;
endpackage : counter_mode_pkg

// *** verilog/counter_mode_control_regs.sv ***
// Mode and control-0 registers of a two-channel counter board on AHB-Lite
// How it works
// RULE1 - Mode registers at index 5/D normally, A/B when compatibility bit set.
// RULE2 - Control register 0 bit 4 selects the compatibility address set.
// RULE3 - Control register 0 at index 6 normally, C when compatibility bit set.
// RULE4 - Host writes zeros to bits 8..15 of relocated control register 0.
// RULE5 - Mode bit 7 selects position acquisition or frequency/pulse measurement.
// RULE6 - Gate style 0: counter runs while gate input active.
// RULE7 - Gate style 1: counter starts at rising gate edge, stops at next.
// RULE8 - Position acquisition: mode bit 5 enables hysteresis.
// RULE9 - Measurement mode: mode bit 5 sets direction, 0 up, 1 down.
// RULE10 - Edge field 0000 fourfold, 0001 twofold, 0101 single edge evaluation.
// RULE11 - Control bits 7 and 6 gate zero-mark interrupts of channels 0 and 1.
// RULE12 - Rising edge on four special inputs raises second group interrupt, bit 5 masks.
// RULE13 - Zero-mark interrupt cleared by buffer read or writing its clear bit.
// RULE14 - Mode bit 4 reads as zero.
// RULE15 - All mode and control register 0 bits reset to zero.
`timescale 1ns/1ps
`include "counter_mode_defs.svh"

module counter_mode_control_regs
    import counter_mode_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic [1:0] gate_in,
    input wire logic [1:0] zero_mark_pulse_in,
    input wire logic [1:0] zero_mark_buf_read_in,
    input wire logic special_in_a_ch0,
    input wire logic special_in_c_ch0,
    input wire logic special_in_a_ch1,
    input wire logic special_in_c_ch1,
    output logic [1:0] measure_function_select_out,
    output logic [1:0] gate_style_out,
    output logic [1:0] hysteresis_en_out,
    output logic [1:0] count_down_out,
    output logic [1:0] count_enable_out,
    output logic [3:0] edge_eval_ch0_out,
    output logic [3:0] edge_eval_ch1_out,
    output logic [1:0] edge_mult_ch0_out,
    output logic [1:0] edge_mult_ch1_out,
    output logic board_compat_select_out,
    output logic group_irq_zero_mark,
    output logic group_irq_special_edge
);

    typedef struct packed {
        bus_phase_t phase;
        logic [3:0] idx;
        logic [7:0] mode0;
        logic [7:0] mode1;
        logic [7:0] ctrl0;
        logic [31:0] rdata;
        logic [1:0] zm_pend;
        logic spec_pend;
        logic [1:0] gate_q;
        logic [1:0] run;
        logic [11:0] spec_sync;
        logic [3:0] spec_last;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic [3:0] spec_raw;
    logic [3:0] spec_now;
    logic compat;
    logic [3:0] ai;

    assign spec_raw = {special_in_c_ch1, special_in_a_ch1, special_in_c_ch0, special_in_a_ch0};
    assign compat = st_r.ctrl0[`CTRL_COMPAT_BIT];
    assign ai = haddr_in[5:2];

    // Edge code to multiplication factor: 2 = x4, 1 = x2, 0 = x1
    function automatic logic [1:0] edge_mult(input logic [3:0] code);
        logic [1:0] m;
        m = 2'h2;
        // RULE10 edge decode
        if (code == `MODE_EDGE_X2) begin
            m = 2'h1;
        end else if (code == `MODE_EDGE_X1) begin
            m = 2'h0;
        end
        return m;
    endfunction : edge_mult

    always_comb begin
        logic [1:0] rise;
        logic [3:0] spec_rise;
        logic [7:0] wb;
        st_nxt = st_r;
        rise = 2'h0;
        spec_rise = 4'h0;
        wb = hwdata_in[7:0];

        // Special inputs: three stages, a change counts once stages two and three agree
        st_nxt.spec_sync = {st_r.spec_sync[7:0], spec_raw};
        for (int i = 0; i < 4; i++) begin
            if (st_r.spec_sync[4 + i] == st_r.spec_sync[8 + i]) begin
                st_nxt.spec_last[i] = st_r.spec_sync[8 + i];
                spec_rise[i] = st_r.spec_sync[8 + i] & ~st_r.spec_last[i];
            end
        end

        // Gate edges for the measurement counter enable
        st_nxt.gate_q = gate_in;
        rise = gate_in & ~st_r.gate_q;
        for (int c = 0; c < 2; c++) begin
            logic [7:0] m;
            m = (c == 0) ? st_r.mode0 : st_r.mode1;
            // RULE7 toggle on rising gate
            if (rise[c]) begin
                st_nxt.run[c] = ~st_r.run[c];
            end
            if (!m[`MODE_GATE_BIT]) begin
                st_nxt.run[c] = 1'b0;
            end
        end

        // Data phase of the previous address phase
        st_nxt.phase = bus_idle;
        if (st_r.phase == bus_write) begin
            unique case (st_r.idx)
                // RULE1 mode register decode
                (compat ? `IDX_MODE0_CMP : `IDX_MODE0_STD): begin
                    // RULE14 bit four forced zero
                    st_nxt.mode0 = wb & `MODE_RD_MASK;
                end
                (compat ? `IDX_MODE1_CMP : `IDX_MODE1_STD): begin
                    st_nxt.mode1 = wb & `MODE_RD_MASK;
                end
                // RULE3 control register decode
                (compat ? `IDX_CTRL0_CMP : `IDX_CTRL0_STD): begin
                    // RULE2 compatibility bit stored here
                    st_nxt.ctrl0 = wb;
                end
                `IDX_IRQ_CLEAR: begin
                    // RULE13 clear by write one
                    if (hwdata_in[`CLR_ZM0_BIT]) begin
                        st_nxt.zm_pend[0] = 1'b0;
                    end
                    if (hwdata_in[`CLR_ZM1_BIT]) begin
                        st_nxt.zm_pend[1] = 1'b0;
                    end
                    if (hwdata_in[`CLR_SPEC_BIT]) begin
                        st_nxt.spec_pend = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // RULE13 clear by buffer read
        for (int c = 0; c < 2; c++) begin
            if (zero_mark_buf_read_in[c]) begin
                st_nxt.zm_pend[c] = 1'b0;
            end
        end
        // Set wins over any clear in the same cycle
        st_nxt.zm_pend = st_nxt.zm_pend | zero_mark_pulse_in;
        // RULE12 special edge capture
        if (|spec_rise) begin
            st_nxt.spec_pend = 1'b1;
        end

        // New address phase; reads are answered with zero wait states
        if (hsel_in && hready_in && htrans_in[1]) begin
            st_nxt.idx = ai;
            st_nxt.phase = hwrite_in ? bus_write : bus_read;
            st_nxt.rdata = 32'h0000_0000;
            if (!hwrite_in) begin
                if (ai == (compat ? `IDX_MODE0_CMP : `IDX_MODE0_STD)) begin
                    st_nxt.rdata[7:0] = st_nxt.mode0;
                end else if (ai == (compat ? `IDX_MODE1_CMP : `IDX_MODE1_STD)) begin
                    st_nxt.rdata[7:0] = st_nxt.mode1;
                end else if (ai == (compat ? `IDX_CTRL0_CMP : `IDX_CTRL0_STD)) begin
                    // RULE4 upper byte reads zero
                    st_nxt.rdata[7:0] = st_nxt.ctrl0;
                end else if (ai == `IDX_IRQ_STATUS) begin
                    st_nxt.rdata[2:0] = {st_nxt.spec_pend, st_nxt.zm_pend};
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            // RULE15 all registers cleared
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign hrdata_out = st_r.rdata;

    // RULE5 function select
    assign measure_function_select_out = {st_r.mode1[`MODE_FUNC_BIT], st_r.mode0[`MODE_FUNC_BIT]};
    assign gate_style_out = {st_r.mode1[`MODE_GATE_BIT], st_r.mode0[`MODE_GATE_BIT]};
    // RULE8 hysteresis only in position mode
    assign hysteresis_en_out = {st_r.mode1[`MODE_HYST_BIT] & ~st_r.mode1[`MODE_FUNC_BIT],
                                st_r.mode0[`MODE_HYST_BIT] & ~st_r.mode0[`MODE_FUNC_BIT]};
    // RULE9 direction in measurement mode
    assign count_down_out = {st_r.mode1[`MODE_HYST_BIT] & st_r.mode1[`MODE_FUNC_BIT],
                             st_r.mode0[`MODE_HYST_BIT] & st_r.mode0[`MODE_FUNC_BIT]};
    // RULE6 level gate or edge-toggled run
    assign count_enable_out[0] = st_r.mode0[`MODE_FUNC_BIT] &
        (st_r.mode0[`MODE_GATE_BIT] ? st_r.run[0] : gate_in[0]);
    assign count_enable_out[1] = st_r.mode1[`MODE_FUNC_BIT] &
        (st_r.mode1[`MODE_GATE_BIT] ? st_r.run[1] : gate_in[1]);
    assign edge_eval_ch0_out = st_r.mode0[`MODE_EDGE_MSB:0];
    assign edge_eval_ch1_out = st_r.mode1[`MODE_EDGE_MSB:0];
    assign edge_mult_ch0_out = edge_mult(st_r.mode0[`MODE_EDGE_MSB:0]);
    assign edge_mult_ch1_out = edge_mult(st_r.mode1[`MODE_EDGE_MSB:0]);
    assign board_compat_select_out = compat;
    // RULE11 zero-mark enables
    assign group_irq_zero_mark = (st_r.zm_pend[0] & st_r.ctrl0[`CTRL_ZM0_EN_BIT]) |
                                 (st_r.zm_pend[1] & st_r.ctrl0[`CTRL_ZM1_EN_BIT]);
    // RULE12 common special mask
    assign group_irq_special_edge = st_r.spec_pend & st_r.ctrl0[`CTRL_SPEC_EN_BIT];

endmodule : counter_mode_control_regs

// *** testbench/counter_mode_asserts.sv ***
// Port-level assertions for the counter mode/control register bank
`timescale 1ns/1ps
module counter_mode_asserts (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic hsel_in,
    input wire logic hwrite_in,
    input wire logic [1:0] htrans_in,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic [1:0] gate_in,
    input wire logic [1:0] zero_mark_pulse_in,
    input wire logic [1:0] zero_mark_buf_read_in,
    input wire logic [1:0] measure_function_select_out,
    input wire logic [1:0] gate_style_out,
    input wire logic [1:0] hysteresis_en_out,
    input wire logic [1:0] count_down_out,
    input wire logic [1:0] count_enable_out,
    input wire logic board_compat_select_out,
    input wire logic group_irq_zero_mark
);
default clocking cb @(posedge clk_in);
endclocking
default disable iff (!resetn_in);
////////////////////////////////////////////////////////////////////////////////
sequence gate_rise_s;
    measure_function_select_out[0] && gate_style_out[0] && $rose(gate_in[0]);
endsequence
a_bus_okay: assert property (hreadyout_out && !hresp_out)
    else $error("bus not ready or not okay");
a_compat_write: assert property ($changed(board_compat_select_out)
    |-> $past(hsel_in && hwrite_in && htrans_in[1], 2)) else $error("compat moved unwritten");
a_pos_idle: assert property (!measure_function_select_out[0] |-> !count_enable_out[0])
    else $error("count in position mode");
a_level_gate: assert property (measure_function_select_out[1] && !gate_style_out[1]
    |-> count_enable_out[1] == gate_in[1]) else $error("level gate not followed");
a_edge_gate: assert property (gate_rise_s
    |=> count_enable_out[0] != $past(count_enable_out[0])) else $error("edge gate no toggle");
a_hyst_pos: assert property (hysteresis_en_out != 2'h0
    |-> (hysteresis_en_out & measure_function_select_out) == 2'h0) else $error("hyst in meas");
a_dir_meas: assert property (count_down_out != 2'h0
    |-> (count_down_out & ~measure_function_select_out) == 2'h0) else $error("dir in pos");
a_zm_clear: assert property (zero_mark_buf_read_in == 2'h3 && zero_mark_pulse_in == 2'h0
    |=> !group_irq_zero_mark) else $error("zero mark irq not cleared");
endmodule : counter_mode_asserts
bind counter_mode_control_regs counter_mode_asserts i_counter_mode_asserts (.*);

// *** testbench/host_bus_model.sv ***
// Host processor model issuing single-word AHB-Lite transfers
`timescale 1ns/1ps
module host_bus_model (
    input wire logic clk_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_in,
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [31:0] hwdata_out
);
initial begin
    haddr_out = 32'h0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hwdata_out = 32'h0;
end
// Not pipelined: each transfer finishes before the next address phase
task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk_in);
    haddr_out <= a;
    hwrite_out <= w;
    htrans_out <= 2'h2;
    hwdata_out <= ~hwdata_out;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    htrans_out <= 2'h0;
    hwdata_out <= d;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    q = hrdata_in;
endtask : xfer
endmodule : host_bus_model

// *** testbench/tb_counter_mode_control_regs.sv ***
// Self-checking bench for the counter mode/control register bank
`timescale 1ns/1ps
module tb_counter_mode_control_regs;
logic clk_in = 1'b0, resetn_in = 1'b0, hsel_in = 1'b1;
logic [2:0] hsize_in = 3'h2;
logic [1:0] gate_in = 2'h0, zero_mark_pulse_in = 2'h0, zero_mark_buf_read_in = 2'h0;
logic special_in_a_ch0 = 1'b0, special_in_c_ch0 = 1'b0, special_in_a_ch1 = 1'b0;
logic special_in_c_ch1 = 1'b0;
logic [31:0] hrdata_out, haddr_in, hwdata_in, rd;
logic [1:0] htrans_in, measure_function_select_out, gate_style_out, hysteresis_en_out;
logic [1:0] count_down_out, count_enable_out, edge_mult_ch0_out, edge_mult_ch1_out;
logic [3:0] edge_eval_ch0_out, edge_eval_ch1_out;
logic hreadyout_out, hresp_out, hwrite_in, board_compat_select_out;
logic group_irq_zero_mark, group_irq_special_edge;
wire hready_in = hreadyout_out;
int num_errors = 0, checks_done = 0, cyc = 0;
logic [95:0] rows [6] = '{{32'h14, 32'h1FF, 32'hEF}, {32'h34, 32'hA5, 32'hA5},
    {32'h18, 32'h0F, 32'h0F}, {32'h28, 32'hFF, 32'h00}, {32'h14, 32'h01, 32'h01},
    {32'h14, 32'h25, 32'h25}};
counter_mode_control_regs i_counter_mode_control_regs (.*);
host_bus_model i_host_bus_model (.clk_in(clk_in), .hready_in(hready_in), .hrdata_in(hrdata_out),
    .haddr_out(haddr_in), .htrans_out(htrans_in), .hwrite_out(hwrite_in), .hwdata_out(hwdata_in));
always #5 clk_in = ~clk_in;
////////////////////////////////////////////////////////////////////////////////
task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
        num_errors++;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
endtask : cmp
task automatic wr(input logic [31:0] a, input logic [31:0] d);
    i_host_bus_model.xfer(1'b1, a, d, rd);
    @(posedge clk_in);
endtask : wr
task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    i_host_bus_model.xfer(1'b0, a, 32'h0, rd);
    cmp(rd, e);
endtask : rdchk
task automatic zm(input logic [1:0] p, input logic [1:0] r);
    @(posedge clk_in);
    zero_mark_pulse_in <= p;
    zero_mark_buf_read_in <= r;
    @(posedge clk_in);
    zero_mark_pulse_in <= 2'h0;
    zero_mark_buf_read_in <= 2'h0;
    repeat (2) @(posedge clk_in);
endtask : zm
task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
        $display("Testbench passed");
    end else begin
        $display("Testbench failed");
    end
    $finish;
endtask : summarize
////////////////////////////////////////////////////////////////////////////////
// Hang guard, far above the roughly 150 cycles needed
always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
        num_errors++;
        summarize();
    end
end
initial begin
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 6; i++) begin
        wr(rows[i][95:64], rows[i][63:32]);
        rdchk(rows[i][95:64], rows[i][31:0]);
    end
    $display("register rows done");
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    rdchk(32'h14, 32'h0);
    rdchk(32'h18, 32'h0);
    rdchk(32'h34, 32'h0);
    $display("reset test done");
    wr(32'h18, 32'h10);
    cmp(32'(board_compat_select_out), 32'h1);
    rdchk(32'h30, 32'h10);
    rdchk(32'h18, 32'h0);
    wr(32'h28, 32'hC0);
    wr(32'h2C, 32'hA0);
    rdchk(32'h28, 32'hC0);
    rdchk(32'h14, 32'h0);
    cmp(32'({measure_function_select_out, hysteresis_en_out, count_down_out}), 32'h32);
    for (int i = 0; i < 3; i++) begin
        @(posedge clk_in);
        gate_in <= (i == 0) ? 2'h3 : 2'(i - 1);
        repeat (2) @(posedge clk_in);
        cmp(32'(count_enable_out), (i == 0) ? 32'h3 : 32'(2 - i));
    end
    $display("compat and gate test done");
    wr(32'h30, 32'hF0);
    zm(2'h1, 2'h0);
    cmp(32'(group_irq_zero_mark), 32'h1);
    zm(2'h0, 2'h3);
    cmp(32'(group_irq_zero_mark), 32'h0);
    zm(2'h2, 2'h0);
    wr(32'h04, 32'h100);
    cmp(32'(group_irq_zero_mark), 32'h0);
    wr(32'h30, 32'h10);
    zm(2'h1, 2'h0);
    cmp(32'(group_irq_zero_mark), 32'h0);
    special_in_c_ch1 <= 1'b1;
    repeat (8) @(posedge clk_in);
    cmp(32'(group_irq_special_edge), 32'h0);
    wr(32'h30, 32'h30);
    cmp(32'(group_irq_special_edge), 32'h1);
    wr(32'h04, 32'h2);
    cmp(32'(group_irq_special_edge), 32'h0);
    $display("interrupt test done");
    wr(32'h28, 32'h05);
    cmp(32'({edge_eval_ch0_out, edge_mult_ch0_out}), 32'h14);
    wr(32'h2C, 32'h01);
    cmp(32'({edge_eval_ch1_out, edge_mult_ch1_out}), 32'h05);
    rdchk(32'h00, 32'h1);
    $display("edge and status test done");
    summarize();
end
endmodule : tb_counter_mode_control_regs
